// ==== logic/lf_sched_pkg.sv ====
package lf_sched_pkg;

  // ------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // ------------------------------------------------------------
  localparam int unsigned APB_AW       = 12;
  localparam logic [7:0]  IDX_CTRL     = 8'h20;
  localparam logic [7:0]  IDX_TIMING   = 8'h21;
  localparam logic [7:0]  IDX_STATUS   = 8'h23;
  localparam logic [11:0] ADDR_CTRL    = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_TIMING  = {2'h0, IDX_TIMING, 2'h0};
  localparam logic [11:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT  = 7;
  localparam int unsigned CTRL_SRES_BIT = 6;
  localparam int unsigned CTRL_CAR_BIT = 5;
  localparam int unsigned STS_ON_BIT   = 7;
  localparam int unsigned STS_INIT_BIT = 6;
  localparam int unsigned STS_HOLD_BIT = 5;
  localparam int unsigned STS_CONT_BIT = 4;
  localparam int unsigned STS_LFO_BIT  = 0;
  localparam logic [7:0]  TIMING_RST   = 8'h60;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  // ------------------------------------------------------------
  // Interval and on-time codes, timing
  // ------------------------------------------------------------
  localparam logic [3:0]  IVL_CONT     = 4'h0;
  localparam logic [3:0]  IVL_MIN_CODE = 4'h3;
  localparam logic [3:0]  IVL_MAX_CODE = 4'hB;
  localparam logic [3:0]  ON_MAX_CODE  = 4'hA;
  localparam int unsigned CNT_W        = 13;
  localparam int unsigned LFO_PERIOD_MS = 1;
  localparam int unsigned INIT_TIME_MS = 2;
  localparam int unsigned INIT_TICKS   = INIT_TIME_MS / LFO_PERIOD_MS;
  localparam int unsigned GAP_TICKS    = 2;

  typedef struct packed {
    logic [3:0] interval_sel;
    logic [3:0] on_sel;
  } timing_t;

  typedef struct packed {
    logic receiver_enable;
    logic carrier_mode;
  } ctrl_t;

endpackage : lf_sched_pkg

// ==== logic/lf_tick_sync.sv ====
`timescale 1ns/100ps
module lf_tick_sync (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_lfo,
  output logic      o_tick,
  output logic      o_level
);

  logic s1_r, s2_r, s3_r;
  logic level_nxt, tick_nxt;

  // ------------------------------------------------------------
  // Level accepted once second and third stage agree
  // ------------------------------------------------------------
  always_comb begin
    level_nxt = o_level;
    tick_nxt  = 1'b0;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
      tick_nxt  = s3_r & ~o_level;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      o_level <= 1'b0;
      o_tick  <= 1'b0;
    end else begin
      s1_r    <= i_lfo;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      o_level <= level_nxt;
      o_tick  <= tick_nxt;
    end
  end

endmodule : lf_tick_sync

// ==== logic/lf_receiver_sample_scheduler.sv ====
// Function
// - Bits 7:4 of timing register pick the interval between detector turn-ons.
// - Interval code zero keeps the detector continuously on.
// - Interval code 0011 starts a sampling window every 16 oscillator periods.
// - Higher interval codes double the period from 32 up to 4096.
// - After an interval write, first interval starts at next oscillator edge.
// - Receiver reset loads the interval field with 0110.
// - Bits 3:0 pick the detector on time at each interval start.
// - On time is net; up to 2 ms warm-up comes from the off time.
// - Carrier mode with signal: cut on time short when evaluation ends.
// - Data mode with signal: hold detector on until message end.
// - Reset clears the on-time field.
// - On-time code zero gives one oscillator cycle per interval.
// - Other on-time codes give 2 up to 1024 oscillator cycles.
// - Control bit 5 selects data receive (0) or carrier detect (1).
// - Continuous mode: after a good message, stop and restart after 2-3 periods.
`timescale 1ns/100ps
module lf_receiver_sample_scheduler #(
  parameter int unsigned INIT_TICKS = lf_sched_pkg::INIT_TICKS,
  parameter int unsigned GAP_TICKS  = lf_sched_pkg::GAP_TICKS
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_lfo,
  input  wire logic        i_signal_detected,
  input  wire logic        i_eval_done,
  input  wire logic        i_msg_end,
  input  wire logic        i_rx_success,
  output logic             o_detector_on,
  output logic             o_detector_init,
  output logic             o_receiver_enable,
  output logic             o_carrier_mode
);

  localparam int unsigned CW = lf_sched_pkg::CNT_W;

  if (INIT_TICKS < 1 || INIT_TICKS > 15) begin : g_chk_init
    $error("INIT_TICKS must lie in 1..15");
  end
  if (GAP_TICKS < 2 || GAP_TICKS > 255) begin : g_chk_gap
    $error("GAP_TICKS must lie in 2..255");
  end

  typedef enum logic [2:0] {
    ST_OFF, ST_WAIT, ST_ON, ST_HOLD, ST_IDLE, ST_CONT, ST_GAP
  } sched_st_t;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  lf_sched_pkg::ctrl_t   ctrl_r, ctrl_nxt;
  lf_sched_pkg::timing_t timing_r, timing_nxt;
  sched_st_t             st_r, st_nxt;
  logic [CW-1:0]         ivl_cnt_r, ivl_cnt_nxt;
  logic [CW-1:0]         on_cnt_r, on_cnt_nxt;
  logic [7:0]            gap_cnt_r, gap_cnt_nxt;
  logic                  det_nxt, init_nxt;
  logic [31:0]           prdata_nxt;
  logic                  pready_nxt, pslverr_nxt;
  logic                  lfo_tick, lfo_level;
  logic [CW-1:0]         ivl_len, on_len;
  logic                  wr_acc, wr_ctrl, wr_timing, sres;
  logic                  last_ivl, last_on, is_cont;

  lf_tick_sync lf_tick_sync_inst (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_lfo     (i_lfo),
    .o_tick    (lfo_tick),
    .o_level   (lfo_level)
  );

  // ------------------------------------------------------------
  // Duration decode
  // ------------------------------------------------------------
  function automatic logic [CW-1:0] ivl_of(input logic [3:0] s);
    logic [3:0] c;
    c = s;
    if (s < lf_sched_pkg::IVL_MIN_CODE) c = lf_sched_pkg::IVL_MIN_CODE;
    if (s > lf_sched_pkg::IVL_MAX_CODE) c = lf_sched_pkg::IVL_MAX_CODE;
    return CW'(1) << (c + 4'h1);
  endfunction : ivl_of

  function automatic logic [CW-1:0] on_of(input logic [3:0] s);
    logic [3:0] c;
    c = s;
    if (s > lf_sched_pkg::ON_MAX_CODE) c = lf_sched_pkg::ON_MAX_CODE;
    return CW'(1) << c;
  endfunction : on_of

  always_comb begin
    ivl_len  = ivl_of(timing_r.interval_sel);
    on_len   = on_of(timing_r.on_sel);
    last_ivl = (ivl_cnt_r == ivl_len - CW'(1));
    last_on  = (on_cnt_r == on_len - CW'(1));
    is_cont  = (timing_r.interval_sel == lf_sched_pkg::IVL_CONT);
  end

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  always_comb begin
    wr_acc    = psel & penable & pready & pwrite;
    wr_ctrl   = wr_acc & (paddr == lf_sched_pkg::ADDR_CTRL);
    wr_timing = wr_acc & (paddr == lf_sched_pkg::ADDR_TIMING);
    sres      = wr_ctrl & pwdata[lf_sched_pkg::CTRL_SRES_BIT];
    ctrl_nxt   = ctrl_r;
    timing_nxt = timing_r;
    if (sres) begin
      ctrl_nxt   = '0;
      timing_nxt = lf_sched_pkg::TIMING_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_nxt.receiver_enable = pwdata[lf_sched_pkg::CTRL_EN_BIT];
        ctrl_nxt.carrier_mode    = pwdata[lf_sched_pkg::CTRL_CAR_BIT];
      end
      if (wr_timing) begin
        timing_nxt = pwdata[7:0];
      end
    end
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    if (psel & ~penable) begin
      unique case (paddr)
        lf_sched_pkg::ADDR_CTRL: begin
          prdata_nxt[lf_sched_pkg::CTRL_EN_BIT]  = ctrl_r.receiver_enable;
          prdata_nxt[lf_sched_pkg::CTRL_CAR_BIT] = ctrl_r.carrier_mode;
        end
        lf_sched_pkg::ADDR_TIMING: begin
          prdata_nxt[7:0] = timing_r;
        end
        lf_sched_pkg::ADDR_STATUS: begin
          prdata_nxt[lf_sched_pkg::STS_ON_BIT]   = o_detector_on;
          prdata_nxt[lf_sched_pkg::STS_INIT_BIT] = o_detector_init;
          prdata_nxt[lf_sched_pkg::STS_HOLD_BIT] = (st_r == ST_HOLD);
          prdata_nxt[lf_sched_pkg::STS_CONT_BIT] = (st_r == ST_CONT) | (st_r == ST_GAP);
          prdata_nxt[lf_sched_pkg::STS_LFO_BIT]  = lfo_level;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sampling scheduler
  // ------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    ivl_cnt_nxt = ivl_cnt_r;
    on_cnt_nxt  = on_cnt_r;
    gap_cnt_nxt = gap_cnt_r;
    unique case (st_r)
      ST_OFF: begin
        st_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (lfo_tick) begin
          ivl_cnt_nxt = '0;
          on_cnt_nxt  = '0;
          st_nxt      = is_cont ? ST_CONT : ST_ON;
        end
      end
      ST_CONT: begin
        if (i_rx_success) begin
          gap_cnt_nxt = '0;
          st_nxt      = ST_GAP;
        end
      end
      ST_GAP: begin
        if (lfo_tick) begin
          gap_cnt_nxt = gap_cnt_r + 8'h01;
          if (gap_cnt_r == 8'(GAP_TICKS)) begin
            st_nxt = ST_CONT;
          end
        end
      end
      ST_ON, ST_HOLD, ST_IDLE: begin
        if (st_r == ST_ON && ctrl_r.carrier_mode && i_signal_detected && i_eval_done) begin
          st_nxt = ST_IDLE;
        end
        if (st_r == ST_HOLD && i_msg_end) begin
          st_nxt = ST_IDLE;
        end
        if (lfo_tick) begin
          if (last_ivl) begin
            ivl_cnt_nxt = '0;
            on_cnt_nxt  = '0;
            st_nxt      = (st_nxt == ST_HOLD) ? ST_HOLD : ST_ON;
          end else begin
            ivl_cnt_nxt = ivl_cnt_r + CW'(1);
            if (st_nxt == ST_ON) begin
              on_cnt_nxt = on_cnt_r + CW'(1);
              if (last_on) begin
                st_nxt = (!ctrl_r.carrier_mode && i_signal_detected) ? ST_HOLD
                                                                    : ST_IDLE;
              end
            end
          end
        end
      end
    endcase
    if (wr_timing) begin
      st_nxt      = ST_WAIT;
      ivl_cnt_nxt = '0;
      on_cnt_nxt  = '0;
    end
    if (!ctrl_r.receiver_enable || sres) begin
      st_nxt      = ST_OFF;
      ivl_cnt_nxt = '0;
      on_cnt_nxt  = '0;
      gap_cnt_nxt = '0;
    end
    det_nxt  = (st_nxt == ST_ON) | (st_nxt == ST_HOLD) | (st_nxt == ST_CONT);
    init_nxt = (st_nxt == ST_IDLE)
             & (ivl_cnt_nxt >= ivl_len - CW'(INIT_TICKS));
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_r          <= lf_sched_pkg::ctrl_t'(2'h0);
      timing_r        <= lf_sched_pkg::TIMING_RST;
      st_r            <= ST_OFF;
      ivl_cnt_r       <= '0;
      on_cnt_r        <= '0;
      gap_cnt_r       <= '0;
      o_detector_on   <= 1'b0;
      o_detector_init <= 1'b0;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      o_receiver_enable <= 1'b0;
      o_carrier_mode  <= 1'b0;
    end else begin
      ctrl_r          <= ctrl_nxt;
      timing_r        <= timing_nxt;
      st_r            <= st_nxt;
      ivl_cnt_r       <= ivl_cnt_nxt;
      on_cnt_r        <= on_cnt_nxt;
      gap_cnt_r       <= gap_cnt_nxt;
      o_detector_on   <= det_nxt;
      o_detector_init <= init_nxt;
      prdata          <= prdata_nxt;
      pready          <= pready_nxt;
      pslverr         <= pslverr_nxt;
      o_receiver_enable <= ctrl_nxt.receiver_enable;
      o_carrier_mode  <= ctrl_nxt.carrier_mode;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  sequence s_wrap_tick;
    lfo_tick && last_ivl && !wr_timing && ctrl_r.receiver_enable && !sres
      && (st_r == ST_ON || st_r == ST_IDLE);
  endsequence

  sequence s_first_tick;
    st_r == ST_WAIT && lfo_tick && !wr_timing && ctrl_r.receiver_enable && !sres;
  endsequence

  a_reset_load: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    i_srst |=> timing_r == 8'h60 && timing_r.on_sel == 4'h0)
    else $error("timing register not at reset value");

  a_first_start: assert property (s_first_tick |=>
    (is_cont ? st_r == ST_CONT : st_r == ST_ON) && ivl_cnt_r == '0)
    else $error("first interval did not start on oscillator tick");

  a_interval_wrap: assert property (s_wrap_tick |=>
    ivl_cnt_r == '0 && on_cnt_r == '0 && st_r == ST_ON && o_detector_on)
    else $error("interval did not restart at period end");

  a_interval_len: assert property (
    timing_r.interval_sel >= 4'h3 && timing_r.interval_sel <= 4'hB
    |-> ivl_len == (13'h0010 << (timing_r.interval_sel - 4'h3)))
    else $error("interval length decode wrong");

  a_on_end: assert property (
    st_r == ST_ON && lfo_tick && last_on && !last_ivl && !wr_timing
      && ctrl_r.receiver_enable && !sres && !i_signal_detected
    |=> st_r == ST_IDLE && !o_detector_on)
    else $error("detector on window did not end");

  a_carrier_cut: assert property (
    st_r == ST_ON && ctrl_r.carrier_mode && i_signal_detected && i_eval_done
      && !lfo_tick && !wr_timing && ctrl_r.receiver_enable && !sres
    |=> !o_detector_on)
    else $error("carrier evaluation did not cut on time");

  a_data_hold: assert property (
    st_r == ST_HOLD && !i_msg_end && !wr_timing && ctrl_r.receiver_enable && !sres
    |=> o_detector_on && st_r == ST_HOLD)
    else $error("detector released before message end");

  a_cont_on: assert property (
    st_r == ST_CONT && !i_rx_success && ctrl_r.receiver_enable && !wr_timing && !sres
    |=> o_detector_on)
    else $error("continuous mode dropped detector");

  a_gap_restart: assert property (
    st_r == ST_CONT && i_rx_success && ctrl_r.receiver_enable && !wr_timing && !sres
    |=> !o_detector_on ##1 (st_r == ST_GAP) [*2])
    else $error("continuous restart gap missing");

  a_init_off: assert property (o_detector_init |-> !o_detector_on)
    else $error("warm-up overlaps on window");

  a_mode_bit: assert property (
    wr_ctrl && !sres |=> o_carrier_mode == $past(pwdata[5]))
    else $error("carrier mode bit not taken");

  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer timing wrong");

endmodule : lf_receiver_sample_scheduler

// ==== tb/tb_lf_receiver_sample_scheduler.sv ====
`timescale 1ns/100ps
module tb_lf_receiver_sample_scheduler;

  // ------------------------------------------------------------
  // Clock, reset, stimulus signals
  // ------------------------------------------------------------
  localparam int LFO_P = 16;

  logic        i_clk_sys = 1'b0;
  logic        i_srst    = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        i_lfo     = 1'b0;
  logic        i_signal_detected = 1'b0;
  logic        i_eval_done  = 1'b0;
  logic        i_msg_end    = 1'b0;
  logic        i_rx_success = 1'b0;
  logic        o_detector_on;
  logic        o_detector_init;
  logic        o_receiver_enable;
  logic        o_carrier_mode;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          lfo_cnt      = 0;
  logic [31:0] init_cnt;

  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

  always #20 i_clk_sys = ~i_clk_sys;

  // Fast oscillator stand-in so long intervals fit the run
  always @(posedge i_clk_sys) begin
    lfo_cnt <= (lfo_cnt == LFO_P - 1) ? 0 : lfo_cnt + 1;
    i_lfo   <= (lfo_cnt < LFO_P / 2);
  end

  lf_receiver_sample_scheduler lf_receiver_sample_scheduler_inst (
    .i_clk_sys         (i_clk_sys),
    .i_srst            (i_srst),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .i_lfo             (i_lfo),
    .i_signal_detected (i_signal_detected),
    .i_eval_done       (i_eval_done),
    .i_msg_end         (i_msg_end),
    .i_rx_success      (i_rx_success),
    .o_detector_on     (o_detector_on),
    .o_detector_init   (o_detector_init),
    .o_receiver_enable (o_receiver_enable),
    .o_carrier_mode    (o_carrier_mode)
  );

  // ------------------------------------------------------------
  // Bus and measurement tasks
  // ------------------------------------------------------------
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50) `CHK("pready", 1'b1, 1'b0)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b1, a, d, rd, err);
  endtask : apb_wr

  // Cycles until the detector output reaches v; also counts warm-up cycles
  task automatic till(input logic v, output logic [31:0] n);
    n = 0;
    while (o_detector_on !== v && n < 9000) begin
      @(posedge i_clk_sys);
      n++;
      if (o_detector_init === 1'b1) init_cnt++;
    end
  endtask : till

  task automatic cfg(input logic [7:0] t, input logic mode);
    logic [31:0] n;
    apb_wr(lf_sched_pkg::ADDR_CTRL, {26'h0, mode, 5'h0});
    repeat (3 * LFO_P) @(posedge i_clk_sys);
    apb_wr(lf_sched_pkg::ADDR_TIMING, {24'h0, t});
    apb_wr(lf_sched_pkg::ADDR_CTRL, {24'h0, 1'b1, 1'b0, mode, 5'h0});
    @(posedge i_clk_sys);
    `CHK("enable", 1'b1, o_receiver_enable)
    till(1'b1, n);
    `CHK("first on", 1'b1, n <= LFO_P + 8)
  endtask : cfg

  task automatic period(input logic [7:0] t, input logic [31:0] hi_e,
                        input logic [31:0] per_e);
    logic [31:0] x;
    logic [31:0] hi;
    logic [31:0] lo;
    cfg(t, 1'b0);
    till(1'b0, x);
    till(1'b1, x);
    till(1'b0, hi);
    init_cnt = 0;
    till(1'b1, lo);
    `CHK("on length", hi_e, hi)
    `CHK("interval", per_e, hi + lo)
    `CHK("warm-up", 2 * LFO_P, init_cnt)
    $display("test period %0h done", t);
  endtask : period

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] rd;
    logic        err;
    apb_xfer(1'b0, lf_sched_pkg::ADDR_TIMING, 32'h0, rd, err);
    `CHK("timing reset", 32'h0000_0060, rd)
    apb_xfer(1'b0, lf_sched_pkg::ADDR_CTRL, 32'h0, rd, err);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    apb_xfer(1'b0, 12'hFF0, 32'h0, rd, err);
    `CHK("unmapped err", 1'b1, err)
    apb_wr(lf_sched_pkg::ADDR_TIMING, 32'h0000_00A5);
    apb_xfer(1'b0, lf_sched_pkg::ADDR_TIMING, 32'h0, rd, err);
    `CHK("timing rw", 32'h0000_00A5, rd)
    apb_wr(lf_sched_pkg::ADDR_CTRL, 32'h0000_0040);
    apb_xfer(1'b0, lf_sched_pkg::ADDR_TIMING, 32'h0, rd, err);
    `CHK("soft reset", 32'h0000_0060, rd)
    $display("test regs done");
  endtask : test_regs

  task automatic test_cont();
    logic [31:0] n;
    logic [31:0] g;
    logic [31:0] rd;
    logic        err;
    cfg(8'h00, 1'b0);
    n = 0;
    repeat (5 * LFO_P) begin
      @(posedge i_clk_sys);
      if (o_detector_on === 1'b1) n++;
    end
    `CHK("continuous", 5 * LFO_P, n)
    apb_xfer(1'b0, lf_sched_pkg::ADDR_STATUS, 32'h0, rd, err);
    `CHK("status", 4'h9, rd[7:4])
    i_rx_success <= 1'b1;
    @(posedge i_clk_sys);
    i_rx_success <= 1'b0;
    till(1'b0, n);
    till(1'b1, g);
    `CHK("restart gap", 1'b1, g >= 2 * LFO_P && g <= 3 * LFO_P + 4)
    $display("test continuous done");
  endtask : test_cont

  task automatic test_mode(input logic mode);
    logic [31:0] n;
    cfg(mode ? 8'h33 : 8'h30, mode);
    `CHK("mode out", mode, o_carrier_mode)
    till(1'b0, n);
    till(1'b1, n);
    repeat (4) @(posedge i_clk_sys);
    i_signal_detected <= 1'b1;
    i_eval_done       <= mode;
    @(posedge i_clk_sys);
    i_eval_done <= 1'b0;
    if (!mode) begin
      repeat (3 * LFO_P) @(posedge i_clk_sys);
      `CHK("held on", 1'b1, o_detector_on)
      i_msg_end <= 1'b1;
      @(posedge i_clk_sys);
      i_msg_end <= 1'b0;
    end
    till(1'b0, n);
    `CHK("early off", 1'b1, n <= 3)
    i_signal_detected <= 1'b0;
    $display("test mode %0b done", mode);
  endtask : test_mode

  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      $display("[ERR] timeout expected done seen running");
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    test_regs();
    period(8'h30, LFO_P, 16 * LFO_P);
    period(8'h32, 4 * LFO_P, 16 * LFO_P);
    period(8'h41, 2 * LFO_P, 32 * LFO_P);
    test_cont();
    test_mode(1'b1);
    test_mode(1'b0);
    print_verdict();
  end

endmodule : tb_lf_receiver_sample_scheduler
